// ===== hdl/bfps_pkg.sv
package bfps_pkg;

	// ****************************************
	// Timing.
	// ****************************************
	localparam int CLK_KHZ = 200000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SW_FREQ_KHZ = 600;
	localparam int PERIOD_CYCLES = CLK_KHZ / SW_FREQ_KHZ;
	localparam int PER_W = 9;
	localparam int CAL_TIME_US = 1900;
	localparam int CAL_CYCLES = CAL_TIME_US * (CLK_KHZ / 1000);
	localparam int CAL_W = 19;
	localparam int DEAD_TIME_NS = 20;
	localparam int DEAD_CYCLES = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEAD_W = 4;
	localparam int SS_PERIODS = 64;
	localparam int SS_W = 8;

	// ****************************************
	// Fault sequencing.
	// ****************************************
	localparam logic [1:0] FAULT_LIMIT = 2'h3;
	localparam logic [2:0] DUMMY_RUN = 3'h4;
	localparam logic [2:0] DUMMY_START = 3'h5;
	localparam logic [8:0] RECT_STEP = 9'h008;
	localparam logic [7:0] TRIP_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_CAL = 3'h1,
		ST_SS = 3'h3,
		ST_RUN = 3'h2,
		ST_HICCUP = 3'h6,
		ST_THERM = 3'h7
	} bfps_state_type;

endpackage

// ===== hdl/bfps_drive_if.sv
`timescale 1ns/1ps
interface bfps_drive_if;
	logic clkEn;
	logic hsReq;
	logic lsReq;
	logic switchNodeLow;
	logic hsGate;
	logic lsGate;

	modport ctrl (output clkEn, output hsReq, output lsReq, output switchNodeLow, input hsGate, input lsGate);
	modport drv (input clkEn, input hsReq, input lsReq, input switchNodeLow, output hsGate, output lsGate);
endinterface

// ===== hdl/bfps_gate_driver.sv
`timescale 1ns/1ps
module bfps_gate_driver #(
	parameter int DEAD_CYC = bfps_pkg::DEAD_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	bfps_drive_if.drv drv
);

	// ****************************************
	// State.
	// ****************************************
	typedef struct packed {
		logic hs;
		logic ls;
		logic [bfps_pkg::DEAD_W-1:0] dead;
	} bfps_drv_state_type;

	bfps_drv_state_type q;
	bfps_drv_state_type d;

	initial begin
		if (DEAD_CYC < 1 || DEAD_CYC > 15) begin
			$error("Dead time count out of range.");
		end
	end

	// ****************************************
	// Non-overlapping drive with dead time.
	// ****************************************
	always_comb begin
		d = q;
		if (q.dead != '0) begin
			d.dead = q.dead - 1'b1;
		end
		if (q.hs && !drv.hsReq) begin
			d.hs = 1'b0;
			d.dead = bfps_pkg::DEAD_W'(DEAD_CYC);
		end else if (q.ls && !drv.lsReq) begin
			d.ls = 1'b0;
			d.dead = bfps_pkg::DEAD_W'(DEAD_CYC);
		end else if (!q.hs && !q.ls && q.dead == '0) begin
			if (drv.hsReq) begin
				d.hs = 1'b1;
			end else if (drv.lsReq && drv.switchNodeLow) begin
				d.ls = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (drv.clkEn) begin
			q <= d;
		end
	end

	assign drv.hsGate = q.hs;
	assign drv.lsGate = q.ls;

	// ****************************************
	// Checks.
	// ****************************************
	chk_no_overlap: assert property (@(posedge clk_sys) disable iff (!rst_n) !(q.hs && q.ls))
		else $error("Both gate drives asserted.");
	chk_dead_gap: assert property (@(posedge clk_sys) disable iff (!rst_n) $fell(q.hs) |-> !q.ls [*4])
		else $error("Low side drive followed high side without dead time.");

endmodule

// ===== hdl/bfps_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Any switching cycle with an overcurrent on either switch adds one to the count.
// - A switching cycle with no overcurrent subtracts one from the count.
// - A count of three declares a fault and starts hiccup mode.
// - A fault in regulation gives four dummy soft-starts, then one real one.
// - A fault from start-up gives five dummy soft-starts, then one real one.
// - Hiccup repeats forever; only a clean real soft-start returns to regulation.
// - A set level at the clamp during calibration disables all overcurrent sensing.
// - A high-side overcurrent ends the present high-side pulse.
// - Low-side overcurrent is sampled at the valley, while the low side conducts.
// - Gate drives never overlap and are separated by a fixed dead time; the low side also waits for the switch node to fall.
// - With pre-biased output, no pulses until soft-start rises above feedback.
// - The rectifier on time starts narrow and grows each cycle up to 1-D.
// - The good flag is low outside the window, in soft-start, or after a short.
// - Over-temperature stops oscillator and modulator and drives both gates low.
// - When over-temperature clears, a full soft-start restarts the converter.
// - Calibration holds low side off, then latches the trip level until re-enable.
module bfps_sequencer #(
	parameter int CAL_CYC = bfps_pkg::CAL_CYCLES,
	parameter int SS_PER = bfps_pkg::SS_PERIODS
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic enableHigh,
	input wire logic [7:0] tripSetLevel,
	input wire logic tripSetAtClamp,
	input wire logic hsOverCurrent,
	input wire logic lsOverCurrent,
	input wire logic switchNodeLow,
	input wire logic softStartAboveFb,
	input wire logic feedbackInWindow,
	input wire logic overTemp,
	input wire logic [8:0] dutyCycles,
	output logic highSideGateDrive,
	output logic lowSideGateDrive,
	output logic outputGoodOut,
	output logic outputGoodOe,
	output logic [7:0] tripLevel,
	output logic overcurrentProtectOff,
	output logic hiccupActive
);

	// ****************************************
	// State.
	// ****************************************
	typedef struct packed {
		bfps_pkg::bfps_state_type state;
		logic [bfps_pkg::CAL_W-1:0] calCnt;
		logic [bfps_pkg::PER_W-1:0] per;
		logic [bfps_pkg::SS_W-1:0] ssCnt;
		logic [2:0] dummies;
		logic [1:0] faultCnt;
		logic ocSeen;
		logic hsCut;
		logic prebiasWait;
		logic [bfps_pkg::PER_W-1:0] rectOn;
		logic [7:0] tripLevel;
		logic ocpOff;
		logic shortSeen;
		logic goodOe;
		logic hiccup;
	} bfps_seq_state_type;

	localparam logic [bfps_pkg::PER_W-1:0] PERIOD_LAST = bfps_pkg::PER_W'(bfps_pkg::PERIOD_CYCLES - 1);
	localparam logic [bfps_pkg::PER_W-1:0] PERIOD_FULL = bfps_pkg::PER_W'(bfps_pkg::PERIOD_CYCLES);
	localparam logic [bfps_pkg::CAL_W-1:0] CAL_LAST = bfps_pkg::CAL_W'(CAL_CYC - 1);
	localparam logic [bfps_pkg::SS_W-1:0] SS_LAST = bfps_pkg::SS_W'(SS_PER - 1);

	bfps_seq_state_type q;
	bfps_seq_state_type d;
	logic tick;
	logic switching;
	logic ocEn;
	logic hsOnWin;
	logic lsOnWin;
	logic hit;
	logic [bfps_pkg::PER_W-1:0] rectFull;
	logic [bfps_pkg::PER_W-1:0] rectNext;

	bfps_drive_if drive ();

	initial begin
		if (CAL_CYC < 1 || CAL_CYC >= (1 << bfps_pkg::CAL_W)) begin
			$error("Calibration count out of range.");
		end
		if (SS_PER < 1 || SS_PER > (1 << bfps_pkg::SS_W)) begin
			$error("Soft-start period count out of range.");
		end
	end

	// ****************************************
	// Soft-start entry.
	// ****************************************
	function automatic bfps_seq_state_type ssStart(input bfps_seq_state_type s);
		bfps_seq_state_type r;
		r = s;
		r.state = bfps_pkg::ST_SS;
		r.ssCnt = '0;
		r.per = '0;
		r.faultCnt = 2'h0;
		r.ocSeen = 1'b0;
		r.hsCut = 1'b0;
		r.prebiasWait = 1'b1;
		r.rectOn = '0;
		return r;
	endfunction

	// ****************************************
	// Switching cycle decode.
	// ****************************************
	always_comb begin
		tick = (q.per == PERIOD_LAST);
		switching = (q.state == bfps_pkg::ST_SS) || (q.state == bfps_pkg::ST_RUN);
		ocEn = switching && !q.prebiasWait && !q.ocpOff;
		hsOnWin = switching && !q.prebiasWait && (q.per < dutyCycles) && !q.hsCut;
		rectFull = PERIOD_FULL - dutyCycles;
		lsOnWin = switching && !q.prebiasWait && (q.per >= dutyCycles) && (q.per >= PERIOD_FULL - q.rectOn);
		hit = q.ocSeen || (ocEn && hsOverCurrent && hsOnWin) || (ocEn && tick && lsOnWin && lsOverCurrent);
		rectNext = (q.rectOn + bfps_pkg::RECT_STEP >= rectFull) ? rectFull : q.rectOn + bfps_pkg::RECT_STEP;
	end

	// ****************************************
	// Sequencer.
	// ****************************************
	always_comb begin
		d = q;
		if (q.state != bfps_pkg::ST_OFF && q.state != bfps_pkg::ST_CAL && q.state != bfps_pkg::ST_THERM) begin
			d.per = tick ? '0 : q.per + 1'b1;
		end
		if (ocEn && hsOverCurrent && hsOnWin) begin
			d.hsCut = 1'b1;
			d.ocSeen = 1'b1;
		end
		case (q.state)
			bfps_pkg::ST_OFF: begin
				d.per = '0;
				if (enableHigh) begin
					d.state = bfps_pkg::ST_CAL;
					d.calCnt = '0;
				end
			end
			bfps_pkg::ST_CAL: begin
				d.calCnt = q.calCnt + 1'b1;
				if (q.calCnt == CAL_LAST) begin
					d = ssStart(q);
					d.tripLevel = tripSetLevel;
					d.ocpOff = tripSetAtClamp;
				end
			end
			bfps_pkg::ST_SS, bfps_pkg::ST_RUN: begin
				if (q.prebiasWait && softStartAboveFb) begin
					d.prebiasWait = 1'b0;
					d.rectOn = bfps_pkg::RECT_STEP;
				end
				if (tick) begin
					d.ocSeen = 1'b0;
					d.hsCut = 1'b0;
					if (!q.prebiasWait) begin
						d.rectOn = rectNext;
						if (hit) begin
							d.faultCnt = q.faultCnt + 1'b1;
						end else if (q.faultCnt != 2'h0) begin
							d.faultCnt = q.faultCnt - 1'b1;
						end
					end
					if (q.state == bfps_pkg::ST_SS) begin
						d.ssCnt = q.ssCnt + 1'b1;
						if (q.ssCnt == SS_LAST) begin
							d.state = bfps_pkg::ST_RUN;
							d.shortSeen = 1'b0;
						end
					end
					if (hit && !q.prebiasWait && q.faultCnt == bfps_pkg::FAULT_LIMIT - 2'h1) begin
						d.state = bfps_pkg::ST_HICCUP;
						d.shortSeen = 1'b1;
						d.ssCnt = '0;
						d.faultCnt = 2'h0;
						d.dummies = (q.state == bfps_pkg::ST_RUN) ? bfps_pkg::DUMMY_RUN : bfps_pkg::DUMMY_START;
					end
				end
			end
			bfps_pkg::ST_HICCUP: begin
				if (tick) begin
					d.ssCnt = q.ssCnt + 1'b1;
					if (q.ssCnt == SS_LAST) begin
						d.ssCnt = '0;
						d.dummies = q.dummies - 1'b1;
						if (q.dummies == 3'h1) begin
							d = ssStart(q);
						end
					end
				end
			end
			bfps_pkg::ST_THERM: begin
				d.per = '0;
				if (!overTemp) begin
					d = ssStart(q);
				end
			end
			default: begin
				d.state = bfps_pkg::ST_OFF;
			end
		endcase
		if (overTemp && (q.state == bfps_pkg::ST_SS || q.state == bfps_pkg::ST_RUN || q.state == bfps_pkg::ST_HICCUP)) begin
			d.state = bfps_pkg::ST_THERM;
			d.per = '0;
			d.ocSeen = 1'b0;
			d.hsCut = 1'b0;
		end
		if (!enableHigh) begin
			d.state = bfps_pkg::ST_OFF;
			d.per = '0;
			d.ocSeen = 1'b0;
			d.hsCut = 1'b0;
		end
		d.hiccup = (d.state == bfps_pkg::ST_HICCUP);
		d.goodOe = !((d.state == bfps_pkg::ST_RUN) && feedbackInWindow && !d.shortSeen);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{state: bfps_pkg::ST_OFF, tripLevel: bfps_pkg::TRIP_RESET, goodOe: 1'b1, default: '0};
		end else if (clkEn) begin
			q <= d;
		end
	end

	// ****************************************
	// Gate drive.
	// ****************************************
	assign drive.clkEn = clkEn;
	assign drive.hsReq = hsOnWin && !(ocEn && hsOverCurrent);
	assign drive.lsReq = lsOnWin;
	assign drive.switchNodeLow = switchNodeLow;

	bfps_gate_driver #(
		.DEAD_CYC(bfps_pkg::DEAD_CYCLES)
	) u_gate_driver (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.drv(drive.drv)
	);

	assign highSideGateDrive = drive.hsGate;
	assign lowSideGateDrive = drive.lsGate;
	assign outputGoodOut = 1'b0;
	assign outputGoodOe = q.goodOe;
	assign tripLevel = q.tripLevel;
	assign overcurrentProtectOff = q.ocpOff;
	assign hiccupActive = q.hiccup;

	// ****************************************
	// Checks.
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_therm_hold;
		q.state == bfps_pkg::ST_THERM ##1 q.state == bfps_pkg::ST_THERM;
	endsequence

	sequence s_cal_hold;
		q.state == bfps_pkg::ST_CAL ##1 q.state == bfps_pkg::ST_CAL;
	endsequence

	chk_fault_declare: assert property (clkEn && enableHigh && !overTemp && switching && tick && !q.prebiasWait && hit
		&& q.faultCnt == 2'h2 |=> q.state == bfps_pkg::ST_HICCUP)
		else $error("Third overcurrent did not enter hiccup.");
	chk_dummy_run: assert property ($past(q.state) == bfps_pkg::ST_RUN && q.state == bfps_pkg::ST_HICCUP
		|-> q.dummies == 3'h4)
		else $error("Fault in regulation did not load four dummy timeouts.");
	chk_dummy_start: assert property ($past(q.state) == bfps_pkg::ST_SS && q.state == bfps_pkg::ST_HICCUP
		|-> q.dummies == 3'h5)
		else $error("Fault at start-up did not load five dummy timeouts.");
	chk_count_up: assert property (clkEn && enableHigh && !overTemp && switching && tick && !q.prebiasWait
		&& hit && q.faultCnt < 2'h2 |=> q.faultCnt == $past(q.faultCnt) + 2'h1)
		else $error("Fault count did not rise on overcurrent.");
	chk_count_down: assert property (clkEn && enableHigh && !overTemp && switching && tick && !q.prebiasWait
		&& !hit && q.faultCnt != 2'h0 |=> q.faultCnt == $past(q.faultCnt) - 2'h1)
		else $error("Fault count did not fall on a clean cycle.");
	chk_ocp_off: assert property (q.ocpOff |-> !q.ocSeen && !q.hsCut)
		else $error("Overcurrent sensed while protection disabled.");
	chk_prebias_quiet: assert property (q.prebiasWait && $past(q.prebiasWait)
		|-> !highSideGateDrive && !lowSideGateDrive)
		else $error("Switching while waiting for soft-start above feedback.");
	chk_therm_off: assert property (s_therm_hold |-> !highSideGateDrive && !lowSideGateDrive && q.per == '0)
		else $error("Gates or oscillator active in thermal shutdown.");
	chk_good_low: assert property (q.state != bfps_pkg::ST_RUN || q.shortSeen |-> q.goodOe)
		else $error("Good flag released outside clean regulation.");
	chk_cal_ls_off: assert property (s_cal_hold |-> !lowSideGateDrive)
		else $error("Low side driven during calibration.");
	chk_therm_restart: assert property ($past(q.state) == bfps_pkg::ST_THERM && enableHigh && $past(enableHigh)
		&& q.state != bfps_pkg::ST_THERM |-> q.state == bfps_pkg::ST_SS && q.prebiasWait && q.ssCnt == '0)
		else $error("Thermal recovery skipped soft-start.");

endmodule

// ===== sim/bfps_power_stage.sv
`timescale 1ns/1ps
// ****************************************
// Power stage model.
// ****************************************
module bfps_power_stage (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hsGate,
	input wire logic lsGate,
	input wire logic [1:0] ocCmd,
	output logic switchNodeLow,
	output logic hsOverCurrent,
	output logic lsOverCurrent
);
	logic [1:0] hsHist_q;

	// The node falls two cycles after the high side opens, so low side turn-on waits on it.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hsHist_q <= 2'h0;
		end else begin
			hsHist_q <= {hsHist_q[0], hsGate};
		end
	end
	assign switchNodeLow = !hsGate && !(|hsHist_q);
	// A drop only exists across a switch that conducts.
	assign hsOverCurrent = ocCmd[0] && hsGate;
	assign lsOverCurrent = ocCmd[1] && lsGate;
endmodule

// ===== sim/test_buck_fault_protection_sequencer.sv
`timescale 1ns/1ps
// ****************************************
// Testbench.
// ****************************************
module test_buck_fault_protection_sequencer;
	localparam int CAL = 50;
	localparam int SSP = 4;
	localparam int PER = bfps_pkg::PERIOD_CYCLES;
	localparam int LIMIT = 60000;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic clkEn = 1'b1;
	logic enableHigh = 1'b0;
	logic [7:0] tripSetLevel = 8'h00;
	logic tripSetAtClamp = 1'b0;
	logic softStartAboveFb = 1'b0;
	logic feedbackInWindow = 1'b1;
	logic overTemp = 1'b0;
	logic [8:0] dutyCycles = 9'h064;
	logic [1:0] ocCmd = 2'h0;
	logic hsOc, lsOc, swLow, hsG, lsG, goodOut, goodOe, ocOff, hic;
	logic [7:0] tripLevel;
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;
	int w, w1, c, k;

	always #2.5 clk_sys = ~clk_sys;

	bfps_sequencer #(.CAL_CYC(CAL), .SS_PER(SSP)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
		.enableHigh(enableHigh), .tripSetLevel(tripSetLevel), .tripSetAtClamp(tripSetAtClamp),
		.hsOverCurrent(hsOc), .lsOverCurrent(lsOc), .switchNodeLow(swLow), .softStartAboveFb(softStartAboveFb),
		.feedbackInWindow(feedbackInWindow), .overTemp(overTemp), .dutyCycles(dutyCycles),
		.highSideGateDrive(hsG), .lowSideGateDrive(lsG), .outputGoodOut(goodOut), .outputGoodOe(goodOe),
		.tripLevel(tripLevel), .overcurrentProtectOff(ocOff), .hiccupActive(hic));

	bfps_power_stage stage (.clk_sys(clk_sys), .rst_n(rst_n), .hsGate(hsG), .lsGate(lsG), .ocCmd(ocCmd),
		.switchNodeLow(swLow), .hsOverCurrent(hsOc), .lsOverCurrent(lsOc));

	// ****************************************
	// Helpers.
	// ****************************************
	function automatic int expRuns(input bit fromRun);
		return fromRun ? 4 : 5;
	endfunction

	function automatic logic sel(input int mode);
		return (mode == 0) ? lsG : ((mode == 1) ? hsG : (hsG | lsG));
	endfunction

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		if (n_fail == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic countHigh(input int mode, input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			cyc(1);
			if (sel(mode) === 1'b1) cnt++;
		end
	endtask

	task automatic waitHigh(input int mode);
		int j;
		for (j = 0; j < 3 * PER && sel(mode) !== 1'b1; j++) cyc(1);
	endtask

	task automatic gateWidth(input int mode, output int wd);
		wd = 0;
		waitHigh(mode);
		while (sel(mode) === 1'b1 && wd < PER) begin
			cyc(1);
			wd++;
		end
	endtask

	task automatic hiccupLen(output int n);
		int j;
		n = 0;
		for (j = 0; j < 6 * PER && hic !== 1'b1; j++) cyc(1);
		while (hic === 1'b1 && n < 8 * SSP * PER) begin
			cyc(1);
			n++;
		end
	endtask

	task automatic waitGood();
		for (k = 0; k < 4 * SSP * PER && goodOe !== 1'b0; k++) cyc(1);
	endtask

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_fail++;
			conclude();
		end
	end

	always @(negedge clk_sys) begin
		if (rst_n) chk("gate overlap", hsG & lsG, 1'b0);
	end

	// ****************************************
	// Scenarios.
	// ****************************************
	initial begin
		void'($urandom(80));
		cyc(6);
		chk("reset outputs", {hsG, lsG, goodOe, ocOff, hic, tripLevel}, {5'b00100, 8'h00});
		chk("good data", goodOut, 1'b0);
		rst_n <= 1'b1;
		dutyCycles <= 9'(60 + $urandom % 140);
		tripSetLevel <= 8'($urandom);
		enableHigh <= 1'b1;
		cyc(1);
		countHigh(0, CAL, c);
		chk("ls in cal", c, 0);
		cyc(3);
		chk("trip latched", tripLevel, tripSetLevel);
		chk("ocp on", ocOff, 1'b0);
		countHigh(1, 2 * PER, c);
		chk("prebias hs", c, 0);
		chk("good in ss", goodOe, 1'b1);
		softStartAboveFb <= 1'b1;
		gateWidth(0, w1);
		chk("rect narrow", w1 > 0 && w1 <= bfps_pkg::RECT_STEP, 1'b1);
		repeat (3) gateWidth(0, w);
		chk("rect grows", w > w1, 1'b1);
		waitGood();
		chk("good in run", goodOe, 1'b0);
		feedbackInWindow <= 1'b0;
		cyc(2);
		chk("good out of window", goodOe, 1'b1);
		feedbackInWindow <= 1'b1;
		cyc(2);
		chk("good back in window", goodOe, 1'b0);
		gateWidth(1, w);
		chk("hs width", w > 0 && w <= dutyCycles, 1'b1);
		repeat (6) begin
			gateWidth(1, w);
			waitHigh(1);
			ocCmd <= 2'h1;
			cyc(2);
			chk("hs cut at once", hsG, 1'b0);
			ocCmd <= 2'h0;
		end
		cyc(1);
		chk("alternate no fault", hic, 1'b0);
		ocCmd <= 2'h2;
		hiccupLen(w);
		chk("dummies from run", w, expRuns(1) * SSP * PER);
		ocCmd <= 2'h1;
		gateWidth(1, w);
		chk("hs cut", w < 4, 1'b1);
		hiccupLen(w);
		chk("dummies from start", w, expRuns(0) * SSP * PER);
		ocCmd <= 2'h0;
		waitGood();
		chk("recovered", {goodOe, hic}, 2'b00);
		gateWidth(1, w);
		clkEn <= 1'b0;
		countHigh(2, PER, c);
		chk("frozen gates", c, 0);
		clkEn <= 1'b1;
		overTemp <= 1'b1;
		cyc(2);
		countHigh(2, 2 * PER, c);
		chk("thermal gates", c, 0);
		overTemp <= 1'b0;
		cyc(3);
		chk("thermal ss", goodOe, 1'b1);
		waitGood();
		chk("thermal run", goodOe, 1'b0);
		enableHigh <= 1'b0;
		cyc(3);
		countHigh(2, PER, c);
		chk("shutdown gates", c, 0);
		tripSetAtClamp <= 1'b1;
		enableHigh <= 1'b1;
		cyc(CAL + 4);
		chk("ocp off", ocOff, 1'b1);
		ocCmd <= 2'h3;
		cyc(8 * SSP * PER);
		chk("no fault when off", hic, 1'b0);
		gateWidth(1, w);
		chk("hs uncut", w > 4, 1'b1);
		conclude();
	end
endmodule
